// *** core/sram_access_pkg.sv ***
package sram_access_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 24;
  localparam int BLOCK_BYTES = 4096;
  localparam int NUM_BLOCKS = 4;
  localparam int BLK_W = $clog2(NUM_BLOCKS);
  localparam int BLK_LSB = $clog2(BLOCK_BYTES);
  localparam int ARRAY_BYTES = 16384;
  localparam int WORD_IDX_W = BLK_LSB + BLK_W - 2;
  // control block addresses
  localparam logic [ADDR_W-1:0] CFG_ADDR = 24'h380000;
  localparam logic [ADDR_W-1:0] TEST_ADDR = 24'h380004;
  // field positions, msb-first bit 0 sits at index 31
  localparam int LOCK_BIT = 31;
  localparam int DIS_BIT = 30;
  localparam int TWO_BIT = 29;
  localparam int PROT_TOP = 11;
  localparam int GROUP_STRIDE = 3;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h0;
  localparam logic [DATA_W-1:0] CFG_WMASK = 32'he0000fff;
  localparam logic [DATA_W-1:0] TEST_READ = 32'h0;
  localparam logic [DATA_W-1:0] ERR_READ = 32'h0;
  // big-endian byte lanes
  localparam logic [3:0] BE_BYTE0 = 4'h8;
  localparam logic [3:0] BE_HALF_HI = 4'hc;
  localparam logic [3:0] BE_HALF_LO = 4'h3;
  localparam logic [3:0] BE_WORD = 4'hf;

  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} xfer_size_t;
  typedef enum logic {ST_IDLE, ST_DATA} state_t;
  typedef struct packed {
    logic reg_space;
    logic [ADDR_W-1:0] addr;
    logic write;
    xfer_size_t size;
    logic [DATA_W-1:0] wdata;
    logic instr;
    logic sup;
  } req_t;
endpackage

// *** core/mem_port_if.sv ***
`timescale 1ns/10ps
interface mem_port_if #(parameter int AW = 12, parameter int DW = 32);
  logic re;
  logic we;
  logic [DW/8-1:0] be;
  logic [AW-1:0] idx;
  logic [DW-1:0] wdata;
  logic alt_ld;
  logic [DW-1:0] alt_data;
  logic [DW-1:0] rdata;
  modport ctrl (output re, we, be, idx, wdata, alt_ld, alt_data, input rdata);
  modport mem (input re, we, be, idx, wdata, alt_ld, alt_data, output rdata);
endinterface // mem_port_if

// *** core/sram_word_array.sv ***
`timescale 1ns/10ps
module sram_word_array #(
  parameter int DEPTH = 4096,
  parameter int DW = 32
) (
  input wire logic clk,
  input wire logic rst,
  mem_port_if.mem mp
);
  logic [DW-1:0] store [DEPTH];
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;

  always_ff @(posedge clk) begin
    for (int i = 0; i < DW/8; i++) begin
      if (mp.we && mp.be[i]) begin
        store[mp.idx][8*i +: 8] <= mp.wdata[8*i +: 8];
      end
    end
  end

  // control-side data wins over the array read
  always_comb begin
    rdata_nxt = rdata_r;
    if (mp.alt_ld) begin
      rdata_nxt = mp.alt_data;
    end else if (mp.re) begin
      rdata_nxt = store[mp.idx];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign mp.rdata = rdata_r;
endmodule // sram_word_array

// *** core/sram_access_control.sv ***
`timescale 1ns/10ps
module sram_access_control
  import sram_access_pkg::*;
#(
  parameter int ARRAY_BYTES_P = ARRAY_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic reg_space,
  input wire logic [sram_access_pkg::ADDR_W-1:0] addr,
  input wire logic write,
  input wire sram_access_pkg::xfer_size_t size,
  input wire logic [sram_access_pkg::DATA_W-1:0] wdata,
  input wire logic instr_fetch,
  input wire logic supervisor,
  output logic ready,
  output logic ack,
  output logic transfer_error,
  output logic [sram_access_pkg::DATA_W-1:0] rdata
);
  import sram_access_pkg::*;

  state_t state_r, state_nxt;
  req_t q_r, q_nxt, cur, op;
  logic [DATA_W-1:0] cfg_r, cfg_nxt;
  logic ready_r, ready_nxt, ack_r, ack_nxt, err_r, err_nxt;
  logic accept, op_v, acc_err, misaligned, in_range, hit_cfg, hit_tst, cfg_wr;
  logic blk_ro, blk_do, blk_so;
  logic [NUM_BLOCKS-1:0] ro_g, do_g, so_g;
  logic [BLK_W-1:0] blk;
  logic [3:0] be;

  mem_port_if #(.AW(WORD_IDX_W), .DW(DATA_W)) mp ();

  sram_word_array #(.DEPTH(ARRAY_BYTES_P/4), .DW(DATA_W)) u_arr (
    .clk(clk),
    .rst(rst),
    .mp(mp.mem)
  );

  // per-block protection fields
  for (genvar g = 0; g < NUM_BLOCKS; g++) begin : g_prot
    assign ro_g[g] = cfg_r[PROT_TOP - GROUP_STRIDE*g];
    assign do_g[g] = cfg_r[PROT_TOP - GROUP_STRIDE*g - 1];
    assign so_g[g] = cfg_r[PROT_TOP - GROUP_STRIDE*g - 2];
  end

  always_comb begin
    cur.reg_space = reg_space;
    cur.addr = addr;
    cur.write = write;
    cur.size = size;
    cur.wdata = wdata;
    cur.instr = instr_fetch;
    cur.sup = supervisor;
  end

  assign accept = req && ready_r;

  // operation stage: the request itself, or the registered copy in q_r a cycle later
  always_comb begin
    op_v = 1'b0;
    op = cur;
    if (state_r == ST_DATA) begin
      op_v = 1'b1;
      op = q_r;
    end else if (accept && !cfg_r[TWO_BIT]) begin
      op_v = 1'b1;
    end
  end

  always_comb begin
    blk = op.addr[BLK_LSB +: BLK_W];
    blk_ro = ro_g[blk];
    blk_do = do_g[blk];
    blk_so = so_g[blk];
    in_range = op.addr < ADDR_W'(ARRAY_BYTES_P);
    hit_cfg = op.addr == CFG_ADDR;
    hit_tst = op.addr == TEST_ADDR;
    be = BE_WORD;
    misaligned = 1'b0;
    case (op.size)
      SZ_BYTE: be = BE_BYTE0 >> op.addr[1:0];
      SZ_HALF: begin
        be = op.addr[1] ? BE_HALF_LO : BE_HALF_HI;
        misaligned = op.addr[0];
      end
      SZ_WORD: misaligned = op.addr[1:0] != 2'h0;
      default: misaligned = 1'b1;
    endcase
    if (op.reg_space) begin
      acc_err = !(hit_cfg || hit_tst) || op.size != SZ_WORD;
    end else begin
      acc_err = cfg_r[DIS_BIT]
        || !in_range || misaligned
        || (op.write && blk_ro)
        || (op.instr && blk_do)
        || (!op.sup && blk_so);
    end
  end

  // array side, blocked on any error
  always_comb begin
    mp.re = op_v && !op.reg_space && !op.write && !acc_err;
    mp.we = op_v && !op.reg_space && op.write && !acc_err;
    mp.be = be;
    mp.idx = op.addr[2 +: WORD_IDX_W];
    mp.wdata = op.wdata;
    mp.alt_ld = op_v && (op.reg_space || acc_err);
    if (acc_err) begin
      mp.alt_data = ERR_READ;
    end else if (hit_cfg) begin
      mp.alt_data = cfg_r;
    end else begin
      mp.alt_data = TEST_READ;
    end
  end

  // config register
  always_comb begin
    cfg_wr = op_v && op.reg_space && hit_cfg && op.write && !acc_err
      && !cfg_r[LOCK_BIT];
    cfg_nxt = cfg_r;
    if (cfg_wr) begin
      cfg_nxt = op.wdata & CFG_WMASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // access sequencing
  always_comb begin
    state_nxt = state_r;
    q_nxt = q_r;
    case (state_r)
      ST_IDLE: begin
        if (accept && cfg_r[TWO_BIT]) begin
          state_nxt = ST_DATA;
          q_nxt = cur;
        end
      end
      ST_DATA: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    ready_nxt = state_nxt == ST_IDLE;
    ack_nxt = op_v;
    err_nxt = op_v && acc_err;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      q_r <= '0;
      ready_r <= 1'b1;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      q_r <= q_nxt;
      ready_r <= ready_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end

  assign ready = ready_r;
  assign ack = ack_r;
  assign transfer_error = err_r;
  assign rdata = mp.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_two_accept;
    accept && cfg_r[TWO_BIT];
  endsequence
  sequence s_two_answer;
    !ack_r && !ready_r ##1 ack_r && ready_r;
  endsequence

  chk_two_cycle_timing: assert property (s_two_accept |=> s_two_answer)
    else $error("two-cycle access did not answer on the second cycle");
  chk_single_cycle_ack: assert property (accept && !cfg_r[TWO_BIT] |=> ack_r)
    else $error("single-cycle access did not answer next cycle");
  chk_lock_holds_cfg: assert property (cfg_r[LOCK_BIT] |=> cfg_r == $past(cfg_r))
    else $error("config changed while locked");
  chk_reenable_write: assert property (cfg_wr |=> cfg_r[DIS_BIT] == $past(op.wdata[DIS_BIT]))
    else $error("disable bit did not follow config write");
  chk_disabled_read_err: assert property (
    op_v && !op.reg_space && !op.write && cfg_r[DIS_BIT] |=> ack_r && err_r)
    else $error("read of disabled array not errored");
  chk_read_only_err: assert property (
    op_v && !op.reg_space && op.write && blk_ro |=> err_r)
    else $error("write to read-only block not errored");
  chk_data_only_err: assert property (
    op_v && !op.reg_space && op.instr && blk_do |=> err_r)
    else $error("fetch from data-only block not errored");
  chk_super_only_err: assert property (
    op_v && !op.reg_space && !op.sup && blk_so |=> err_r)
    else $error("user access to supervisor block not errored");
  chk_tail_unusable: assert property (
    op_v && !op.reg_space && op.addr >= ADDR_W'(ARRAY_BYTES_P) |=> err_r)
    else $error("access past populated array not errored");
  chk_err_no_write: assert property (err_nxt |-> !mp.we && !mp.re)
    else $error("errored access touched the array");
  chk_test_reads_zero: assert property (
    op_v && op.reg_space && hit_tst && !op.write && op.size == SZ_WORD
    |=> !err_r && rdata == TEST_READ)
    else $error("test register read not answered as defined");
  chk_reserved_zero: assert property ((cfg_r & ~CFG_WMASK) == '0)
    else $error("reserved config bits set");
endmodule // sram_access_control

// *** sim/bus_master_model.sv ***
`timescale 1ns/10ps
module bus_master_model
  import sram_access_pkg::*;
(
  input wire logic clk,
  input wire logic ready,
  input wire logic ack,
  input wire logic transfer_error,
  input wire logic [sram_access_pkg::DATA_W-1:0] rdata,
  output logic req,
  output logic reg_space,
  output logic [sram_access_pkg::ADDR_W-1:0] addr,
  output logic write,
  output sram_access_pkg::xfer_size_t size,
  output logic [sram_access_pkg::DATA_W-1:0] wdata,
  output logic instr_fetch,
  output logic supervisor
);
  logic err;
  logic [DATA_W-1:0] rd;
  int lat;
  initial begin
    {req, reg_space, addr, write, wdata, instr_fetch, supervisor} = '0;
    size = SZ_WORD;
  end
  // request held until taken, bus scrambled once released
  task automatic xfer(input logic rs, input logic [ADDR_W-1:0] a, input logic w,
      input xfer_size_t sz, input logic [DATA_W-1:0] d, input logic ins, input logic sup);
    @(posedge clk);
    #1;
    {req, reg_space, addr, write, wdata, instr_fetch, supervisor} = {1'b1, rs, a, w, d, ins, sup};
    size = sz;
    // ready is looked at where it has settled, for the edge that follows
    while (ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    req = 1'b0;
    addr = ~a;
    wdata = ~d;
    lat = 1;
    while (ack !== 1'b1 && lat < 8) begin
      @(posedge clk);
      #1;
      lat++;
    end
    err = transfer_error;
    rd = rdata;
  endtask
endmodule // bus_master_model

// *** sim/tb_sram_access_control.sv ***
`timescale 1ns/10ps
module tb_sram_access_control;
  import sram_access_pkg::*;
  logic clk, rst, req, reg_space, write, instr_fetch, supervisor, ready, ack, transfer_error;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  xfer_size_t size;
  int mismatches, cmp_count, cycles;
  sram_access_control dut (.clk(clk), .rst(rst), .req(req), .reg_space(reg_space), .addr(addr),
    .write(write), .size(size), .wdata(wdata), .instr_fetch(instr_fetch),
    .supervisor(supervisor), .ready(ready), .ack(ack), .transfer_error(transfer_error),
    .rdata(rdata));
  bus_master_model m (.clk(clk), .ready(ready), .ack(ack), .transfer_error(transfer_error),
    .rdata(rdata), .req(req), .reg_space(reg_space), .addr(addr), .write(write), .size(size),
    .wdata(wdata), .instr_fetch(instr_fetch), .supervisor(supervisor));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic res(input logic e, input int l);
    chk("transfer_error", {31'h0, e}, {31'h0, m.err});
    chk("latency", 32'(l), 32'(m.lat));
  endtask
  task automatic acc(input logic [23:0] a, input logic w, input xfer_size_t sz,
      input logic [31:0] d, input logic ins, input logic sup);
    m.xfer(1'b0, a, w, sz, d, ins, sup);
  endtask
  task automatic cfg(input logic [31:0] d);
    m.xfer(1'b1, CFG_ADDR, 1'b1, SZ_WORD, d, 1'b0, 1'b1);
  endtask
  task automatic t_reset();
    m.xfer(1'b1, CFG_ADDR, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    chk("config", 32'h0, m.rd);
    m.xfer(1'b1, TEST_ADDR, 1'b1, SZ_WORD, 32'hffffffff, 1'b0, 1'b1);
    res(1'b0, 1);
    m.xfer(1'b1, TEST_ADDR, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    res(1'b0, 1);
    chk("test_reg", 32'h0, m.rd);
    $display("t_reset done");
  endtask
  task automatic t_lanes();
    acc(24'h10, 1'b1, SZ_WORD, 32'h11223344, 1'b0, 1'b1);
    res(1'b0, 1);
    acc(24'h11, 1'b1, SZ_BYTE, 32'h00aa0000, 1'b0, 1'b1);
    acc(24'h12, 1'b1, SZ_HALF, 32'h0000bbcc, 1'b0, 1'b1);
    acc(24'h10, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    res(1'b0, 1);
    chk("rdata", 32'h11aabbcc, m.rd);
    $display("t_lanes done");
  endtask
  task automatic t_two();
    cfg(32'h20000000);
    acc(24'h10, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    res(1'b0, 2);
    chk("rdata", 32'h11aabbcc, m.rd);
    cfg(32'h0);
    acc(24'h10, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    res(1'b0, 1);
    $display("t_two done");
  endtask
  task automatic t_prot();
    logic [23:0] b, o;
    for (int g = 0; g < 4; g++) begin
      b = 24'(g * BLOCK_BYTES) + 24'h8;
      o = 24'(((g + 1) % 4) * BLOCK_BYTES) + 24'h8;
      cfg(32'h0);
      acc(b, 1'b1, SZ_WORD, 32'h5a5a0000 + 32'(g), 1'b0, 1'b1);
      cfg(32'h1 << (31 - 20 - 3 * g));
      acc(b, 1'b1, SZ_WORD, 32'hffffffff, 1'b0, 1'b1);
      res(1'b1, 1);
      acc(o, 1'b1, SZ_WORD, 32'h0, 1'b0, 1'b1);
      res(1'b0, 1);
      acc(b, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
      chk("rdata", 32'h5a5a0000 + 32'(g), m.rd);
      cfg(32'h1 << (31 - 21 - 3 * g));
      acc(b, 1'b0, SZ_WORD, 32'h0, 1'b1, 1'b1);
      res(1'b1, 1);
      chk("rdata", 32'h0, m.rd);
      acc(b, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
      res(1'b0, 1);
      cfg(32'h1 << (31 - 22 - 3 * g));
      acc(b, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b0);
      res(1'b1, 1);
      acc(o, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b0);
      res(1'b0, 1);
    end
    $display("t_prot done");
  endtask
  task automatic t_dis();
    cfg(32'h40000000);
    acc(24'h10, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    res(1'b1, 1);
    chk("rdata", 32'h0, m.rd);
    acc(24'h10, 1'b1, SZ_WORD, 32'hffffffff, 1'b0, 1'b1);
    cfg(32'h0);
    acc(24'h11, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    res(1'b1, 1);
    acc(24'h13, 1'b1, SZ_HALF, 32'hffffffff, 1'b0, 1'b1);
    res(1'b1, 1);
    acc(24'h10, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    res(1'b0, 1);
    chk("rdata", 32'h11aabbcc, m.rd);
    acc(24'h4000, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    res(1'b1, 1);
    $display("t_dis done");
  endtask
  task automatic t_lock();
    cfg(32'h80000000);
    cfg(32'h40000000);
    m.xfer(1'b1, CFG_ADDR, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    chk("config", 32'h80000000, m.rd);
    acc(24'h10, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    res(1'b0, 1);
    $display("t_lock done");
  endtask
  task automatic t_rerun();
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    m.xfer(1'b1, CFG_ADDR, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    chk("config", 32'h0, m.rd);
    cfg(32'h40000000);
    m.xfer(1'b1, CFG_ADDR, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    chk("config", 32'h40000000, m.rd);
    cfg(32'h0);
    acc(24'h10, 1'b0, SZ_WORD, 32'h0, 1'b0, 1'b1);
    res(1'b0, 1);
    $display("t_rerun done");
  endtask
  initial begin
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_lanes();
    t_two();
    t_prot();
    t_dis();
    t_lock();
    t_rerun();
    final_report();
  end
endmodule // tb_sram_access_control
